// ---- hdl/ssc_pkg.sv ----
// Package of constants and types for the sampling converter control link
// Function
// - Trigger high keeps sample/hold tracking input
// - Host holds trigger high 4 or 5 us
// - Bypassed sample/hold needs 100 ns trigger pulse
// - Trigger fall: hold, reset sequencer, start conversion
// - Triggers ignored until conversion completes
// - Start word: MSB low, others high
// - Status high throughout the conversion
// - One bit low per internal clock, MSB first
// - One clock per bit, 14 or 15 cycles
// - Status falls after last bit, within limit
// - Host enables output buffers after status falls
// - Host reads result while next sample acquires; ssc_host reads it before raising the next trigger
// - Host conversion rate at most 25/20 kHz
// - Straight, offset binary or two's complement coding
// - Trigger and sample/hold control may be joined
// - Host switches channels at sample/hold edges; ssc_host has no channel select and switches none
// - Result read as word or two enabled bytes
// - True MSB binary, complement MSB two's complement
package ssc_pkg;
    // =========================================================
    // Widths and system clock rate
    localparam int RES_BITS = 15;
    localparam int BYTE_BITS = 8;
    localparam int BIT_IDX_W = 4;
    localparam int CLK_MHZ = 50;
    // =========================================================
    // Timing, in their own units, then cycles at 50 MHz
    localparam int T_ACQ14_US = 4;
    localparam int T_ACQ15_US = 5;
    localparam int T_TRIG_MIN_NS = 100;
    localparam int T_CONV14_US = 35;
    localparam int T_CONV15_US = 44;
    localparam int T_RATE14_KHZ = 25;
    localparam int T_RATE15_KHZ = 20;
    localparam int ACQ14_CYC = T_ACQ14_US * CLK_MHZ;
    localparam int ACQ15_CYC = T_ACQ15_US * CLK_MHZ;
    localparam int TRIG_MIN_CYC = (T_TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV14_CYC = T_CONV14_US * CLK_MHZ;
    localparam int CONV15_CYC = T_CONV15_US * CLK_MHZ;
    localparam int PERIOD14_CYC = (CLK_MHZ * 1000) / T_RATE14_KHZ;
    localparam int PERIOD15_CYC = (CLK_MHZ * 1000) / T_RATE15_KHZ;
    // Internal bit clock divide: one bit decision per this many cycles
    localparam int BIT_DIV_CYC = 100;
    localparam int DIV_W = 12;
    // =========================================================
    // Reset values
    localparam logic [RES_BITS-1:0] RESULT_RST = 15'h0000;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_RST = 4'h0;
    // =========================================================
    // Coding selection
    typedef enum logic [1:0] {
        SSC_CODE_BINARY = 2'h0,
        SSC_CODE_OFFSET = 2'h1,
        SSC_CODE_TWOS = 2'h2
    } ssc_code_e;
endpackage

// ---- hdl/ssc_if.sv ----
// Interface joining the converter control and its bus host
`timescale 1ns/1ps
`default_nettype none
interface ssc_if;
    logic                          trigger;
    logic                          sh_control;
    logic                          status;
    logic                          high_byte_output_enable;
    logic                          low_byte_output_enable;
    logic [ssc_pkg::BYTE_BITS-1:0] data_out;
    logic                          data_oe;
    logic [ssc_pkg::BYTE_BITS-1:0] data_hi_out;
    logic                          data_hi_oe;
    modport device (
        input  trigger, sh_control, high_byte_output_enable, low_byte_output_enable,
        output status, data_out, data_oe, data_hi_out, data_hi_oe
    );
    modport host (
        output trigger, sh_control, high_byte_output_enable, low_byte_output_enable,
        input  status, data_out, data_oe, data_hi_out, data_hi_oe
    );
endinterface
`default_nettype wire

// ---- hdl/ssc_sar_core.sv ----
// Successive approximation sequencer with its internal bit clock
`timescale 1ns/1ps
`default_nettype none
module ssc_sar_core (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    // Control
    input  wire logic                         start,
    input  wire logic                         wide,
    input  wire logic                         comp_keep,
    // State
    output logic                              busy,
    output logic [ssc_pkg::RES_BITS-1:0]      word,
    output logic [ssc_pkg::BIT_IDX_W-1:0]     bit_idx,
    output logic                              bit_tick
);
    logic [ssc_pkg::DIV_W-1:0] div;

    // =========================================================
    // Internal clock: rising edge modelled as a periodic tick
    always_ff @(posedge clk_sys) begin
        if (reset || start || !busy) begin
            div <= '0;
        end else if (div == ssc_pkg::DIV_W'(ssc_pkg::BIT_DIV_CYC - 1)) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    assign bit_tick = busy && !start && (div == ssc_pkg::DIV_W'(ssc_pkg::BIT_DIV_CYC - 1));

    // =========================================================
    // Trial word and bit decisions
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy    <= 1'b0;
            word    <= ssc_pkg::RESULT_RST;
            bit_idx <= ssc_pkg::BIT_IDX_RST;
        end else if (start) begin
            busy    <= 1'b1;
            // MSB low, rest high as the first trial
            word    <= wide ? 15'h3fff : 15'h1fff;
            bit_idx <= wide ? 4'he : 4'hd;
        end else if (bit_tick) begin
            // Decide current bit, switch next bit low
            word[bit_idx] <= comp_keep;
            if (bit_idx != 4'h0) begin
                word[bit_idx - 4'h1] <= 1'b0;
                bit_idx <= bit_idx - 4'h1;
            end else begin
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ssc_device.sv ----
// Converter end: trigger handling, sample/hold, status and byte buffers
`timescale 1ns/1ps
`default_nettype none
module ssc_device (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // Link
    ssc_if.device                            link,
    // User side: analog comparator and straps
    input  wire logic                        comp_keep,
    input  wire logic                        wide,
    input  wire logic                        bipolar,
    input  wire logic                        twos_sel,
    output logic                             sh_sampling,
    output logic [ssc_pkg::BIT_IDX_W-1:0]    bit_under_test
);
    logic                           trig_q;
    logic                           start;
    logic                           busy;
    logic                           bit_tick;
    logic [ssc_pkg::RES_BITS-1:0]   word;
    logic [ssc_pkg::BIT_IDX_W-1:0]  bit_idx;
    logic [ssc_pkg::RES_BITS-1:0]   coded;
    logic [ssc_pkg::RES_BITS-1:0]   next_coded;

    // =========================================================
    // Trigger falling edge, ignored during a conversion
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= link.trigger;
        end
    end
    assign start = trig_q && !link.trigger && !busy;

    ssc_sar_core u_core (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .start     (start),
        .wide      (wide),
        .comp_keep (comp_keep),
        .busy      (busy),
        .word      (word),
        .bit_idx   (bit_idx),
        .bit_tick  (bit_tick)
    );

    // =========================================================
    // Sample/hold follows its control while idle; hold from start
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sh_sampling <= 1'b0;
        end else begin
            sh_sampling <= link.sh_control && !busy && !start;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bit_under_test <= ssc_pkg::BIT_IDX_RST;
            link.status    <= 1'b0;
        end else begin
            bit_under_test <= bit_idx;
            // High from start to last decision
            link.status    <= start || (busy && !(bit_tick && bit_idx == 4'h0));
        end
    end

    // =========================================================
    // Output coding: complement MSB gives two's complement
    always_comb begin
        next_coded = wide ? word : {1'b0, word[13:0]};
        if (bipolar && twos_sel) begin
            if (wide) begin
                next_coded[14] = ~word[14];
            end else begin
                next_coded[13] = ~word[13];
            end
        end
    end

    // Final one cycle after status falls; held until the next accepted start or a strap change
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            coded <= ssc_pkg::RESULT_RST;
        end else begin
            coded <= next_coded;
        end
    end

    // =========================================================
    // Byte buffers, each driven only with its own enable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            link.data_out    <= '0;
            link.data_oe     <= 1'b0;
            link.data_hi_out <= '0;
            link.data_hi_oe  <= 1'b0;
        end else begin
            link.data_out    <= coded[7:0];
            link.data_oe     <= link.low_byte_output_enable;
            link.data_hi_out <= {1'b0, coded[14:8]};
            link.data_hi_oe  <= link.high_byte_output_enable;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ssc_host.sv ----
// Bus host end: trigger pulses and byte reads of the result
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    // Link
    ssc_if.host                               link,
    // User side
    input  wire logic                         go,
    input  wire logic                         wide,
    input  wire logic                         use_sh,
    output logic [ssc_pkg::RES_BITS-1:0]      result,
    output logic                              result_valid
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_TRIG = 5'h02,
        H_WAIT = 5'h04,
        H_READ = 5'h08,
        H_GAP  = 5'h10
    } ssc_hstate_e;
    ssc_hstate_e state;
    logic [12:0] cnt;
    logic        stat_q;

    function automatic logic [12:0] trig_len(input logic w, input logic s);
        if (!s) begin
            return 13'(ssc_pkg::TRIG_MIN_CYC);
        end
        return w ? 13'(ssc_pkg::ACQ15_CYC) : 13'(ssc_pkg::ACQ14_CYC);
    endfunction

    // =========================================================
    // Sequence; trigger drives sample/hold control too
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= H_IDLE;
            cnt <= '0;
            stat_q <= 1'b0;
            link.trigger <= 1'b0;
            link.sh_control <= 1'b0;
            link.high_byte_output_enable <= 1'b0;
            link.low_byte_output_enable <= 1'b0;
            result <= ssc_pkg::RESULT_RST;
            result_valid <= 1'b0;
        end else begin
            stat_q <= link.status;
            result_valid <= 1'b0;
            cnt <= cnt + 13'h1;
            unique case (state)
                H_IDLE: begin
                    if (go) begin
                        state <= H_TRIG;
                        cnt <= '0;
                        link.trigger <= 1'b1;
                        link.sh_control <= use_sh;
                    end
                end
                H_TRIG: begin
                    if (cnt >= trig_len(wide, use_sh) - 13'h1) begin
                        link.trigger <= 1'b0;
                        link.sh_control <= 1'b0;
                        state <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (stat_q && !link.status) begin
                        // Read both bytes after status falls
                        link.high_byte_output_enable <= 1'b1;
                        link.low_byte_output_enable <= 1'b1;
                        state <= H_READ;
                    end
                end
                H_READ: begin
                    if (link.data_oe && link.data_hi_oe) begin
                        result <= {link.data_hi_out[6:0], link.data_out};
                        result_valid <= 1'b1;
                        link.high_byte_output_enable <= 1'b0;
                        link.low_byte_output_enable <= 1'b0;
                        state <= H_GAP;
                    end
                end
                H_GAP: begin
                    // Keep start spacing within the rate limit
                    if (cnt >= (wide ? 13'(ssc_pkg::PERIOD15_CYC)
                                     : 13'(ssc_pkg::PERIOD14_CYC))) begin
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- test/ssc_link_monitor.sv ----
// Checker of the trigger, status and byte buffer signals on the link
`timescale 1ns/1ps
`default_nettype none
module ssc_link_monitor (
    // Clock and reset
    input wire logic                          clk_sys,
    input wire logic                          reset,
    // Link
    input wire logic                          trigger,
    input wire logic                          sh_control,
    input wire logic                          status,
    input wire logic                          high_byte_output_enable,
    input wire logic                          low_byte_output_enable,
    input wire logic [ssc_pkg::BYTE_BITS-1:0] data_out,
    input wire logic                          data_oe,
    input wire logic [ssc_pkg::BYTE_BITS-1:0] data_hi_out,
    input wire logic                          data_hi_oe
);
    // =========================================================
    // Helper: length of the present status pulse
    logic [11:0] high_cnt;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            high_cnt <= 12'h000;
        end else if (status) begin
            high_cnt <= high_cnt + 12'h001;
        end else begin
            high_cnt <= 12'h000;
        end
    end
    // =========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_start_raises_status: assert property ($fell(trigger) && !status |=> status)
        else $error("status did not rise after trigger fall");
    a_busy_ignores_trig: assert property (status && $fell(trigger) |=> status)
        else $error("conversion restarted while busy");
    a_conv_len_bits: assert property (
        $fell(status) |-> high_cnt == 12'h578 || high_cnt == 12'h5dc)
        else $error("conversion length not one bit period per bit");
    a_conv_time_max: assert property (status |-> high_cnt < ssc_pkg::CONV15_CYC)
        else $error("conversion exceeded its time limit");
    a_enable_after_done: assert property ($rose(low_byte_output_enable) |-> !status)
        else $error("output enabled during conversion");
    a_byte_oe_follow: assert property (
        data_oe == $past(low_byte_output_enable)
        && data_hi_oe == $past(high_byte_output_enable))
        else $error("byte drive not following its own enable");
    a_hi_byte_top: assert property (data_hi_oe |-> data_hi_out[7] == 1'b0)
        else $error("unused high byte bit driven high");
    a_result_stable: assert property (
        data_oe && $past(data_oe) && !status |-> $stable(data_out) && $stable(data_hi_out))
        else $error("result changed while being read");
    a_trig_min_width: assert property ($fell(trigger) |-> $past(trigger, 5))
        else $error("trigger pulse too short");
    a_sh_joins_trig: assert property (sh_control |-> trigger)
        else $error("sample/hold control high without trigger");
endmodule
`default_nettype wire

// ---- test/ssc_tb.sv ----
// Testbench joining both link ends and running the conversion cases
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // =========================================================
    // Stimulus and observation
    logic                         clk_sys = 1'b0;
    logic                         reset   = 1'b1;
    logic                         go = 1'b0;
    logic                         wide = 1'b0;
    logic                         use_sh = 1'b0;
    logic                         comp_keep = 1'b0;
    logic                         bipolar = 1'b0;
    logic                         twos_sel = 1'b0;
    logic                         sh_sampling;
    logic [ssc_pkg::BIT_IDX_W-1:0] bit_under_test;
    logic [14:0]                  keep_pat = 15'h0000;
    logic [ssc_pkg::RES_BITS-1:0] result;
    logic                         result_valid;
    int                           error_cnt = 0;
    int                           checks = 0;
    int                           cyc = 0;
    ssc_if link ();
    always #10 clk_sys = ~clk_sys;
    ssc_device u_ssc_device (.clk_sys(clk_sys), .reset(reset), .link(link),
        .comp_keep(comp_keep), .wide(wide), .bipolar(bipolar), .twos_sel(twos_sel),
        .sh_sampling(sh_sampling), .bit_under_test(bit_under_test));
    ssc_host u_ssc_host (.clk_sys(clk_sys), .reset(reset), .link(link), .go(go),
        .wide(wide), .use_sh(use_sh), .result(result), .result_valid(result_valid));
    ssc_link_monitor u_ssc_link_monitor (.clk_sys(clk_sys), .reset(reset),
        .trigger(link.trigger), .sh_control(link.sh_control), .status(link.status),
        .high_byte_output_enable(link.high_byte_output_enable),
        .low_byte_output_enable(link.low_byte_output_enable), .data_out(link.data_out),
        .data_oe(link.data_oe), .data_hi_out(link.data_hi_out), .data_hi_oe(link.data_hi_oe));
    // =========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Cut a hang short; all cases together need about 13300 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            final_report();
        end
    end
    // =========================================================
    // Comparator model: an uneven pattern catches a wrong bit order
    always @(posedge clk_sys) begin
        comp_keep <= keep_pat[bit_under_test];
    end
    // One conversion: straps {wide, use_sh, bipolar, twos, pattern pick}
    task automatic run_case(input logic [4:0] c);
        int n;
        int cnt;
        int t;
        logic sh_seen;
        logic hold_bad;
        logic [14:0] exp;
        n = c[4] ? 15 : 14;
        exp = (c[0] ? 15'h6b35 : 15'h14ca) & 15'((32'h1 << n) - 1);
        if (c[2] && c[1]) exp = exp ^ 15'(32'h1 << (n - 1));
        cnt = 0;
        t = 0;
        sh_seen = 1'b0;
        hold_bad = 1'b0;
        @(posedge clk_sys);
        {wide, use_sh, bipolar, twos_sel} <= c[4:1];
        keep_pat <= c[0] ? 15'h6b35 : 15'h14ca;
        go <= 1'b1;
        // Hold the request until taken; the host may still be spacing starts
        do begin
            @(negedge clk_sys);
            t++;
        end while (link.trigger !== 1'b1 && t < 8000);
        @(posedge clk_sys);
        go <= 1'b0;
        while (result_valid !== 1'b1 && t < 8000) begin
            @(negedge clk_sys);
            t++;
            if (link.status === 1'b1) cnt++;
            if (link.trigger === 1'b1 && sh_sampling === 1'b1) sh_seen = 1'b1;
            if (link.status === 1'b1 && sh_sampling !== 1'b0) hold_bad = 1'b1;
        end
        check(16'(t < 8000), 16'h0001);
        check(16'(result), 16'(exp));
        check({1'b0, link.data_hi_out[6:0], link.data_out}, 16'(exp));
        check(16'(cnt >= n * 100 && cnt <= n * 100 + 1), 16'h0001);
        if (c[3]) check(16'(sh_seen), 16'h0001);
        check(16'(hold_bad), 16'h0000);
        @(negedge clk_sys);
        check(16'(result_valid), 16'h0000);
        repeat (20) @(negedge clk_sys);
        check(16'(result), 16'(exp));
        if (c[3]) check(16'(sh_sampling), 16'h0000);
        $display("test %b done", c);
    endtask
    // =========================================================
    // Main sequence; back-to-back cases stress the start spacing
    logic [4:0] cases [6] = '{5'b11001, 5'b01001, 5'b10000, 5'b11110, 5'b00111, 5'b11101};
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (cases[i]) run_case(cases[i]);
        final_report();
    end
endmodule
`default_nettype wire
